// ### rtl/pcct_top.v
`timescale 1ns/1ps
`default_nettype none
`include "pcct_defs.vh"
module pcct_top (
  input  wire                   clock_in,
  input  wire                   reset_in,
  input  wire [7:0]             reg_addr_in,
  input  wire [7:0]             reg_wr_data_in,
  input  wire                   reg_wr_in,
  input  wire                   reg_rd_in,
  output reg  [7:0]             reg_rd_data_out,
  input  wire                   cyc_req_in,
  input  wire                   cyc_io_in,
  input  wire                   cyc_write_in,
  input  wire                   cyc_window_in,
  input  wire [`PCCT_ADDR_W-1:0] cyc_addr_in,
  output reg                    cyc_ready_out,
  output reg                    cyc_done_out,
  output reg                    cyc_refused_out,
  output reg                    ata_mode_out,
  output reg                    card_ce1_n_out,
  output reg                    card_ce2_n_out,
  output reg                    card_oe_n_out,
  output reg                    card_we_n_out,
  output reg                    card_iord_n_out,
  output reg                    card_iowr_n_out,
  output reg  [`PCCT_ADDR_W-1:0] card_addr_out
);
  wire [7:0] setup0;
  wire [7:0] cmd0;
  wire [7:0] rec0;
  wire [7:0] setup1;
  wire [7:0] cmd1;
  wire [7:0] rec1;
  wire [7:0] mode;
  wire [7:0] iowin;

  wire [`PCCT_LEN_W-1:0] setup_len0;
  wire [`PCCT_LEN_W-1:0] setup_len1;
  wire [`PCCT_LEN_W-1:0] cmd_len0;
  wire [`PCCT_LEN_W-1:0] cmd_len1;
  wire [`PCCT_LEN_W-1:0] rec_len0;
  wire [`PCCT_LEN_W-1:0] rec_len1;

  reg  [1:0]             state_reg;
  reg  [`PCCT_LEN_W-1:0] count_reg;
  reg                    set_reg;
  reg                    io_reg;
  reg                    write_reg;

  // timing registers; all writes accepted in either socket mode
  pcct_tmr_reg #(.RESET_VALUE(`PCCT_RST_SETUP), .ADDRESS(`PCCT_ADDR_SETUP0)) u_setup0 (
    .clock_in   (clock_in),
    .reset_in   (reset_in),
    .addr_in    (reg_addr_in),
    .wr_data_in (reg_wr_data_in),
    .wr_in      (reg_wr_in),
    .value_out  (setup0)
  );
  pcct_tmr_reg #(.RESET_VALUE(`PCCT_RST_CMD0), .ADDRESS(`PCCT_ADDR_CMD0)) u_cmd0 (
    .clock_in   (clock_in),
    .reset_in   (reset_in),
    .addr_in    (reg_addr_in),
    .wr_data_in (reg_wr_data_in),
    .wr_in      (reg_wr_in),
    .value_out  (cmd0)
  );
  pcct_tmr_reg #(.RESET_VALUE(`PCCT_RST_REC), .ADDRESS(`PCCT_ADDR_REC0)) u_rec0 (
    .clock_in   (clock_in),
    .reset_in   (reset_in),
    .addr_in    (reg_addr_in),
    .wr_data_in (reg_wr_data_in),
    .wr_in      (reg_wr_in),
    .value_out  (rec0)
  );
  pcct_tmr_reg #(.RESET_VALUE(`PCCT_RST_SETUP), .ADDRESS(`PCCT_ADDR_SETUP1)) u_setup1 (
    .clock_in   (clock_in),
    .reset_in   (reset_in),
    .addr_in    (reg_addr_in),
    .wr_data_in (reg_wr_data_in),
    .wr_in      (reg_wr_in),
    .value_out  (setup1)
  );
  pcct_tmr_reg #(.RESET_VALUE(`PCCT_RST_CMD1), .ADDRESS(`PCCT_ADDR_CMD1)) u_cmd1 (
    .clock_in   (clock_in),
    .reset_in   (reset_in),
    .addr_in    (reg_addr_in),
    .wr_data_in (reg_wr_data_in),
    .wr_in      (reg_wr_in),
    .value_out  (cmd1)
  );
  pcct_tmr_reg #(.RESET_VALUE(`PCCT_RST_REC), .ADDRESS(`PCCT_ADDR_REC1)) u_rec1 (
    .clock_in   (clock_in),
    .reset_in   (reset_in),
    .addr_in    (reg_addr_in),
    .wr_data_in (reg_wr_data_in),
    .wr_in      (reg_wr_in),
    .value_out  (rec1)
  );
  pcct_tmr_reg #(.RESET_VALUE(`PCCT_RST_MODE), .ADDRESS(`PCCT_ADDR_MODE)) u_mode (
    .clock_in   (clock_in),
    .reset_in   (reset_in),
    .addr_in    (reg_addr_in),
    .wr_data_in (reg_wr_data_in),
    .wr_in      (reg_wr_in),
    .value_out  (mode)
  );
  pcct_tmr_reg #(.RESET_VALUE(`PCCT_RST_IOWIN), .ADDRESS(`PCCT_ADDR_IOWIN)) u_iowin (
    .clock_in   (clock_in),
    .reset_in   (reset_in),
    .addr_in    (reg_addr_in),
    .wr_data_in (reg_wr_data_in),
    .wr_in      (reg_wr_in),
    .value_out  (iowin)
  );

  pcct_len u_len_s0 (.value_in(setup0), .length_out(setup_len0));
  pcct_len u_len_s1 (.value_in(setup1), .length_out(setup_len1));
  pcct_len u_len_c0 (.value_in(cmd0),   .length_out(cmd_len0));
  pcct_len u_len_c1 (.value_in(cmd1),   .length_out(cmd_len1));
  pcct_len u_len_r0 (.value_in(rec0),   .length_out(rec_len0));
  pcct_len u_len_r1 (.value_in(rec1),   .length_out(rec_len1));

  wire ata = mode[`PCCT_MODE_ATA_BIT];

  // memory cycles always run on timer set 0
  wire req_set = cyc_io_in & (cyc_window_in ? iowin[`PCCT_IOWIN1_SET_BIT]
                                            : iowin[`PCCT_IOWIN0_SET_BIT]);
  wire req_refused = cyc_req_in & cyc_ready_out & ata & ~cyc_io_in;
  wire req_taken   = cyc_req_in & cyc_ready_out & ~req_refused;

  wire [`PCCT_LEN_W-1:0] req_setup_len = req_set ? setup_len1 : setup_len0;
  wire [`PCCT_LEN_W-1:0] cur_cmd_len   = set_reg ? cmd_len1   : cmd_len0;
  wire [`PCCT_LEN_W-1:0] cur_rec_len   = set_reg ? rec_len1   : rec_len0;
  wire                   last          = (count_reg == {{(`PCCT_LEN_W-1){1'b0}}, 1'b1});

  // ata drive sees only a2..a0 and a9; a9 carries cs1, ce1 carries cs0
  wire                    ata_cs1  = cyc_addr_in[`PCCT_ATA_CS_ADDR_BIT];
  wire [`PCCT_ADDR_W-1:0] ata_addr = {{(`PCCT_ADDR_W-10){1'b0}}, ~ata_cs1, 6'h00, cyc_addr_in[2:0]};

  // phase boundaries for the pin drivers; the count decrement for the sequencer
  wire                   in_idle   = (state_reg == `PCCT_ST_IDLE);
  wire                   setup_end = (state_reg == `PCCT_ST_SETUP) & last;
  wire                   cmd_end   = (state_reg == `PCCT_ST_CMD) & last;
  wire [`PCCT_LEN_W-1:0] count_dec = count_reg - {{(`PCCT_LEN_W-1){1'b0}}, 1'b1};

  // phase sequencer: each phase loads its own length from the chosen set
  always @(posedge clock_in) begin
    if (reset_in) begin
      state_reg       <= `PCCT_ST_IDLE;
      count_reg       <= {`PCCT_LEN_W{1'b0}};
      set_reg         <= 1'b0;
      io_reg          <= 1'b0;
      write_reg       <= 1'b0;
      cyc_ready_out   <= 1'b1;
      cyc_done_out    <= 1'b0;
      cyc_refused_out <= 1'b0;
    end else begin
      cyc_done_out    <= 1'b0;
      cyc_refused_out <= req_refused;
      case (state_reg)
        `PCCT_ST_IDLE: begin
          if (req_taken) begin
            state_reg     <= `PCCT_ST_SETUP;
            count_reg     <= req_setup_len;
            set_reg       <= req_set;
            io_reg        <= cyc_io_in;
            write_reg     <= cyc_write_in;
            cyc_ready_out <= 1'b0;
          end
        end
        `PCCT_ST_SETUP: begin
          if (last) begin
            state_reg <= `PCCT_ST_CMD;
            count_reg <= cur_cmd_len;
          end else begin
            count_reg <= count_dec;
          end
        end
        `PCCT_ST_CMD: begin
          if (last) begin
            state_reg <= `PCCT_ST_RECOV;
            count_reg <= cur_rec_len;
          end else begin
            count_reg <= count_dec;
          end
        end
        `PCCT_ST_RECOV: begin
          if (last) begin
            state_reg     <= `PCCT_ST_IDLE;
            cyc_ready_out <= 1'b1;
            cyc_done_out  <= 1'b1;
          end else begin
            count_reg <= count_dec;
          end
        end
        default: begin
          state_reg     <= `PCCT_ST_IDLE;
          cyc_ready_out <= 1'b1;
        end
      endcase
    end
  end

  // card enables: low from the take through the end of the command phase; in ata mode ce2 stays high and ce1 goes low only for cs0
  always @(posedge clock_in) begin
    if (reset_in) begin
      card_ce1_n_out <= 1'b1;
      card_ce2_n_out <= 1'b1;
    end else if (req_taken) begin
      if (ata) begin
        card_ce1_n_out <= ata_cs1;
        card_ce2_n_out <= 1'b1;
      end else begin
        card_ce1_n_out <= 1'b0;
        card_ce2_n_out <= 1'b0;
      end
    end else if (cmd_end) begin
      card_ce1_n_out <= 1'b1;
      card_ce2_n_out <= 1'b1;
    end
  end

  // address holds after the cycle until the next take
  always @(posedge clock_in) begin
    if (reset_in) begin
      card_addr_out <= {`PCCT_ADDR_W{1'b0}};
    end else if (req_taken) begin
      if (ata) begin
        card_addr_out <= ata_addr;
      end else begin
        card_addr_out <= cyc_addr_in;
      end
    end
  end

  // i/o strobes, active for the whole command phase
  always @(posedge clock_in) begin
    if (reset_in) begin
      card_iord_n_out <= 1'b1;
      card_iowr_n_out <= 1'b1;
    end else if (setup_end & io_reg) begin
      card_iord_n_out <= write_reg;
      card_iowr_n_out <= ~write_reg;
    end else if (cmd_end) begin
      card_iord_n_out <= 1'b1;
      card_iowr_n_out <= 1'b1;
    end
  end

  // memory strobes; oe parks low in ata mode, recovery included
  always @(posedge clock_in) begin
    if (reset_in) begin
      card_oe_n_out <= 1'b1;
      card_we_n_out <= 1'b1;
    end else if (setup_end & ~io_reg) begin
      card_oe_n_out <= write_reg;
      card_we_n_out <= ~write_reg;
    end else if (cmd_end | in_idle) begin
      card_oe_n_out <= ~ata;
      card_we_n_out <= 1'b1;
    end
  end

  always @(posedge clock_in) begin
    if (reset_in) begin
      ata_mode_out <= 1'b0;
    end else begin
      ata_mode_out <= ata;
    end
  end

  reg [7:0] rd_next;

  // unmapped indexes and slots without a read strobe give zero
  always @* begin
    rd_next = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `PCCT_ADDR_SETUP0: rd_next = setup0;
        `PCCT_ADDR_CMD0:   rd_next = cmd0;
        `PCCT_ADDR_REC0:   rd_next = rec0;
        `PCCT_ADDR_SETUP1: rd_next = setup1;
        `PCCT_ADDR_CMD1:   rd_next = cmd1;
        `PCCT_ADDR_REC1:   rd_next = rec1;
        `PCCT_ADDR_MODE:   rd_next = mode;
        `PCCT_ADDR_IOWIN:  rd_next = iowin;
        `PCCT_ADDR_STATUS: rd_next = {3'h0, ata, set_reg, state_reg, ~cyc_ready_out};
        default:           rd_next = 8'h00;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always @(posedge clock_in) begin
    if (reset_in) begin
      reg_rd_data_out <= 8'h00;
    end else begin
      reg_rd_data_out <= rd_next;
    end
  end
endmodule
`default_nettype wire

// ### rtl/pcct_defs.vh
`ifndef PCCT_DEFS_VH
`define PCCT_DEFS_VH

`define PCCT_ADDR_SETUP0     8'h3a
`define PCCT_ADDR_CMD0       8'h3b
`define PCCT_ADDR_REC0       8'h3c
`define PCCT_ADDR_SETUP1     8'h3d
`define PCCT_ADDR_CMD1       8'h3e
`define PCCT_ADDR_REC1       8'h3f
`define PCCT_ADDR_MODE       8'h40
`define PCCT_ADDR_IOWIN      8'h41
`define PCCT_ADDR_STATUS     8'h42

`define PCCT_RST_SETUP       8'h01
`define PCCT_RST_CMD0        8'h05
`define PCCT_RST_CMD1        8'h14
`define PCCT_RST_REC         8'h00
`define PCCT_RST_MODE        8'h00
`define PCCT_RST_IOWIN       8'h00

`define PCCT_PRE_HI          7
`define PCCT_PRE_LO          6
`define PCCT_MUL_HI          5
`define PCCT_MUL_LO          0
`define PCCT_MODE_ATA_BIT    0
`define PCCT_IOWIN0_SET_BIT  3
`define PCCT_IOWIN1_SET_BIT  7
`define PCCT_ATA_CS_ADDR_BIT 9

`define PCCT_SHIFT_W16       4
`define PCCT_SHIFT_W256      8
`define PCCT_SHIFT_W4096     12

`define PCCT_LEN_W           18
`define PCCT_ADDR_W          26

`define PCCT_ST_IDLE         2'h0
`define PCCT_ST_SETUP        2'h1
`define PCCT_ST_CMD          2'h2
`define PCCT_ST_RECOV        2'h3

`endif

// ### rtl/pcct_tmr_reg.v
`timescale 1ns/1ps
`default_nettype none
module pcct_tmr_reg #(
  parameter [7:0] RESET_VALUE = 8'h00,
  parameter [7:0] ADDRESS     = 8'h00
) (
  input  wire       clock_in,
  input  wire       reset_in,
  input  wire [7:0] addr_in,
  input  wire [7:0] wr_data_in,
  input  wire       wr_in,
  output reg  [7:0] value_out
);
  // writes land at once, even mid-cycle; nothing waits for the cycle to end
  always @(posedge clock_in) begin
    if (reset_in) begin
      value_out <= RESET_VALUE;
    end else if (wr_in && addr_in == ADDRESS) begin
      value_out <= wr_data_in;
    end
  end
endmodule
`default_nettype wire

// ### rtl/pcct_len.v
`timescale 1ns/1ps
`default_nettype none
`include "pcct_defs.vh"
module pcct_len (
  input  wire [7:0]                value_in,
  output reg  [`PCCT_LEN_W-1:0]    length_out
);
  reg [`PCCT_LEN_W-1:0] mul_ext;
  reg [`PCCT_LEN_W-1:0] weighted;
  always @* begin
    mul_ext = {{(`PCCT_LEN_W-6){1'b0}}, value_in[`PCCT_MUL_HI:`PCCT_MUL_LO]};
    case (value_in[`PCCT_PRE_HI:`PCCT_PRE_LO])
      2'h0:    weighted = mul_ext;
      2'h1:    weighted = mul_ext << `PCCT_SHIFT_W16;
      2'h2:    weighted = mul_ext << `PCCT_SHIFT_W256;
      default: weighted = mul_ext << `PCCT_SHIFT_W4096;
    endcase
    // largest is 4096*63+1, fits the width with no carry out
    length_out = weighted + {{(`PCCT_LEN_W-1){1'b0}}, 1'b1};
  end
endmodule
`default_nettype wire

// ### dv/pcct_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pcct_checker (
  input wire logic       clock_in,
  input wire logic       reset_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rd_data_out,
  input wire logic       cyc_req_in,
  input wire logic       cyc_io_in,
  input wire logic       cyc_ready_out,
  input wire logic       cyc_done_out,
  input wire logic       cyc_refused_out,
  input wire logic       ata_mode_out,
  input wire logic       card_oe_n_out,
  input wire logic       card_we_n_out,
  input wire logic       card_iord_n_out,
  input wire logic       card_iowr_n_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  sequence s_io_take;
    cyc_req_in && cyc_ready_out && cyc_io_in;
  endsequence
  sequence s_mem_ata;
    cyc_req_in && cyc_ready_out && !cyc_io_in && ata_mode_out;
  endsequence
  // setup, command and recovery are each at least one cycle
  a_take_busy: assert property (s_io_take |=> !cyc_ready_out [*3])
    else $error("ready too soon after take");
  a_mem_refuse: assert property (s_mem_ata |=> cyc_refused_out && cyc_ready_out && card_we_n_out)
    else $error("memory cycle not refused");
  a_ata_pins: assert property (ata_mode_out && $past(ata_mode_out) |-> !card_oe_n_out && card_we_n_out)
    else $error("ata pin levels wrong");
  a_done_single: assert property (cyc_done_out |=> !cyc_done_out)
    else $error("done longer than one cycle");
  a_done_ready: assert property (cyc_done_out |-> cyc_ready_out)
    else $error("done without ready");
  a_recov_gap: assert property ($rose(card_iord_n_out) || $rose(card_iowr_n_out) |-> !cyc_ready_out)
    else $error("no recovery after strobe");
  a_idle_quiet: assert property (cyc_ready_out |-> card_iord_n_out && card_iowr_n_out)
    else $error("strobe active while idle");
  a_rd_quiet: assert property (!$past(reg_rd_in) |-> reg_rd_data_out == 8'h00)
    else $error("read data outside read slot");
endmodule
bind pcct_top pcct_checker chk (.clock_in(clock_in), .reset_in(reset_in), .reg_rd_in(reg_rd_in),
  .reg_rd_data_out(reg_rd_data_out), .cyc_req_in(cyc_req_in), .cyc_io_in(cyc_io_in),
  .cyc_ready_out(cyc_ready_out), .cyc_done_out(cyc_done_out), .cyc_refused_out(cyc_refused_out),
  .ata_mode_out(ata_mode_out), .card_oe_n_out(card_oe_n_out), .card_we_n_out(card_we_n_out),
  .card_iord_n_out(card_iord_n_out), .card_iowr_n_out(card_iowr_n_out));
`default_nettype wire

// ### dv/pcct_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcct_card_model (
  input  wire logic        clock_in,
  input  wire logic        ata_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        iord_n_in,
  input  wire logic        iowr_n_in,
  input  wire logic        ce1_n_in,
  input  wire logic        a9_in,
  output logic      [15:0] width_out,
  output logic      [1:0]  cs_out
);
  logic [15:0] cnt_reg   = 16'h0000;
  logic [15:0] width_reg = 16'h0000;
  logic [1:0]  cs_reg    = 2'b00;
  logic        act;
  // oe is parked low in ata mode, so it is not a strobe there
  assign act       = !we_n_in || !iord_n_in || !iowr_n_in || (!oe_n_in && !ata_in);
  assign width_out = width_reg;
  assign cs_out    = cs_reg;
  always @(posedge clock_in) begin
    if (act) begin
      cnt_reg <= cnt_reg + 16'h0001;
      cs_reg  <= {ce1_n_in, a9_in};
    end else if (cnt_reg != 16'h0000) begin
      width_reg <= cnt_reg;
      cnt_reg   <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ### dv/pc_card_cycle_timing_ata_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcct_defs.vh"
module pc_card_cycle_timing_ata_test;
  typedef struct { logic [7:0] cmd; logic [7:0] rec; logic [31:0] c; logic [31:0] r; } pcct_row_t;
  logic clock_in = 0, reset_in = 1, rd = 0, wr = 0, req = 0, io = 0, wrt = 0, win = 0;
  logic [7:0]  addr = 8'h00, wdat = 8'h00, v;
  logic [25:0] caddr = 26'h0000000;
  wire logic [7:0]  rdata;
  wire logic [25:0] cout;
  wire logic [15:0] width;
  wire logic [1:0]  cs;
  wire logic ready, done, refused, ata, ce1, ce2, oe, we, iord, iowr;
  int n_fail = 0, checks_done = 0, n;
  pcct_row_t rows [6] = '{'{8'h05, 8'h00, 6, 1}, '{8'h3f, 8'h02, 64, 3}, '{8'h41, 8'h40, 17, 1},
                          '{8'h81, 8'h00, 257, 1}, '{8'hc1, 8'h81, 4097, 257}, '{8'h00, 8'hc0, 1, 1}};
  pcct_top dut (.clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_wr_data_in(wdat),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rd_data_out(rdata), .cyc_req_in(req), .cyc_io_in(io),
    .cyc_write_in(wrt), .cyc_window_in(win), .cyc_addr_in(caddr), .cyc_ready_out(ready),
    .cyc_done_out(done), .cyc_refused_out(refused), .ata_mode_out(ata), .card_ce1_n_out(ce1),
    .card_ce2_n_out(ce2), .card_oe_n_out(oe), .card_we_n_out(we), .card_iord_n_out(iord),
    .card_iowr_n_out(iowr), .card_addr_out(cout));
  pcct_card_model card (.clock_in(clock_in), .ata_in(ata), .oe_n_in(oe), .we_n_in(we), .iord_n_in(iord),
    .iowr_n_in(iowr), .ce1_n_in(ce1), .a9_in(cout[9]), .width_out(width), .cs_out(cs));
  always #2.5 clock_in = ~clock_in;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge clock_in);
    wr   <= 1'b0;
  endtask
  task rreg(input logic [7:0] a);
    @(posedge clock_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock_in);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask
  // n ends as the cycle index of done, counted from the taking edge
  task run(input logic i, input logic w, input logic wn, input logic [25:0] a);
    @(posedge clock_in);
    io    <= i;
    wrt   <= w;
    win   <= wn;
    caddr <= a;
    req   <= 1'b1;
    @(posedge clock_in);
    req   <= 1'b0;
    #1 n = 1;
    while (done !== 1'b1 && n < 9000) begin
      @(posedge clock_in);
      #1 n++;
    end
  endtask
  initial begin
    #100000;
    n_fail++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge clock_in);
    reset_in <= 1'b0;
    rreg(`PCCT_ADDR_CMD0);
    check(v, 8'h05);
    rreg(`PCCT_ADDR_CMD1);
    check(v, 8'h14);
    rreg(`PCCT_ADDR_REC0);
    check(v, 8'h00);
    rreg(`PCCT_ADDR_REC1);
    check(v, 8'h00);
    // timing writes only between cycles, while nothing is queued
    foreach (rows[k]) begin
      wreg(`PCCT_ADDR_CMD0, rows[k].cmd);
      wreg(`PCCT_ADDR_REC0, rows[k].rec);
      run(1'b1, k[0], 1'b0, 26'h0000000);
      check(width, rows[k].c);
      check(n, 2 + rows[k].c + rows[k].r + 1);
    end
    wreg(`PCCT_ADDR_CMD0, 8'h05);
    wreg(`PCCT_ADDR_REC0, 8'h00);
    wreg(`PCCT_ADDR_IOWIN, 8'h08);
    run(1'b1, 1'b0, 1'b0, 26'h0000000);
    check(width, 21);
    run(1'b1, 1'b1, 1'b1, 26'h0000000);
    check(width, 6);
    run(1'b0, 1'b1, 1'b0, 26'h2abcdef);
    check(width, 6);
    check(cout, 26'h2abcdef);
    run(1'b0, 1'b0, 1'b0, 26'h0000000);
    check(width, 6);
    wreg(`PCCT_ADDR_MODE, 8'h01);
    repeat (2) @(posedge clock_in);
    #1 check({ata, oe, ce2}, 3'b101);
    @(posedge clock_in);
    io  <= 1'b0;
    req <= 1'b1;
    @(posedge clock_in);
    req <= 1'b0;
    #1 check({refused, ready, we}, 3'b111);
    run(1'b1, 1'b0, 1'b1, 26'h0000205);
    check(cs, 2'b10);
    check(width, 6);
    check(cout, 26'h0000005);
    check(oe, 1'b0);
    run(1'b1, 1'b0, 1'b1, 26'h0000000);
    check(cs, 2'b01);
    wreg(`PCCT_ADDR_REC1, 8'h3c);
    rreg(`PCCT_ADDR_REC1);
    check(v, 8'h3c);
    rreg(8'h10);
    check(v, 8'h00);
    @(posedge clock_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    rreg(`PCCT_ADDR_REC1);
    check(v, 8'h00);
    check({ata, oe}, 2'b01);
    test_done;
  end
endmodule
`default_nettype wire
